// file: mac_fc_pkg.sv
// Constants, register map and types shared by the pause flow control block
package mac_fc_pkg;
   // Register byte offsets on the Wishbone slave
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_ADDR_LO  = 8'h04;
   localparam logic [7:0]  OFS_ADDR_HI  = 8'h08;
   localparam logic [7:0]  OFS_REFRESH  = 8'h0C;
   localparam logic [7:0]  OFS_STATUS   = 8'h10;
   // Control register field positions
   localparam int          CTRL_TX_EN   = 0;
   localparam int          CTRL_RX_EN   = 1;
   localparam int          CTRL_EXT     = 2;
   localparam int          CTRL_AUTO_ON = 3;
   localparam int          CTRL_LEN_DIS = 4;
   localparam int          CTRL_W       = 5;
   // Status register field positions
   localparam int          STS_INH      = 16;
   localparam int          STS_PEND     = 17;
   // Reset values
   localparam logic [4:0]  CTRL_RST     = 5'h00;
   localparam logic [47:0] STATION_RST  = 48'h020000000001;
   localparam logic [15:0] REFRESH_RST  = 16'hFF00;
   // Frame constants, first byte on the wire is the top byte
   localparam logic [47:0] RESERVED_DA  = 48'h0180C2000001;
   localparam logic [15:0] CTRL_TYPE    = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
   localparam int          PAUSE_LEN    = 60;
   localparam int          CTRL_LEN     = 64;
   // Receive statistics word bits
   localparam int          STAT_GOOD    = 0;
   localparam int          STAT_CTRL    = 20;
   // One quantum is 512 bit times, 51.2 ns at 10 Gb/s; least time rounds up
   localparam int          QUANTUM_PS   = 51200;
   localparam int          CLK_PS       = 20000;
   localparam int          QUANTUM_CYC  = (QUANTUM_PS + CLK_PS - 1) / CLK_PS;
   typedef enum {TX_IDLE, TX_CLIENT, TX_PAUSE} tx_state_e;
endpackage

// file: quanta_counter.sv
// Down counter of pause quanta, loadable, with an expiry pulse
`timescale 1ns/1ps
module quanta_counter (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic        tick,
   output logic      [15:0] count_q,
   output logic             done_q
);
   // Load wins over a tick so a restart never loses a quantum to a stale decrement
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= 16'h0000;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (load) begin
            count_q <= load_val;
         end else if (tick && count_q != 16'h0000) begin
            count_q <= count_q - 16'h0001;
            done_q  <= (count_q == 16'h0001);
         end
      end
   end
endmodule

// file: mac_pause_flow_control.sv
// Pause frame generation, reception and transmit inhibit for a 10G MAC
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module mac_pause_flow_control (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pause_req_valid,
   input  wire logic [15:0] pause_req_quanta,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_last,
   output logic             tx_ack,
   output logic             line_tx_valid,
   output logic      [7:0]  line_tx_data,
   output logic             line_tx_last,
   input  wire logic        line_rx_valid,
   input  wire logic [7:0]  line_rx_data,
   input  wire logic        line_rx_last,
   input  wire logic        line_rx_crc_ok,
   output logic             rx_valid,
   output logic      [7:0]  rx_data,
   output logic             rx_last,
   output logic             rx_good,
   output logic             rx_stat_valid,
   output logic      [31:0] rx_stat_word
);
   logic [4:0]                  ctrl_q;
   logic [47:0]                 station_q;
   logic [15:0]                 refresh_q;
   mac_fc_pkg::tx_state_e       state_q;
   logic [5:0]                  idx_q;
   logic                        pend_q;
   logic [15:0]                 pend_quanta_q;
   logic [15:0]                 frame_quanta_q;
   logic [15:0]                 held_quanta_q;
   logic                        req_prev_q;
   logic                        held_q;
   logic [1:0]                  div_q;
   logic                        tick_q;
   logic [6:0]                  rcnt_q;
   logic                        da_res_q;
   logic                        da_sta_q;
   logic [15:0]                 type_q;
   logic [15:0]                 op_q;
   logic [15:0]                 rq_q;
   logic [15:0]                 inh_count;
   logic                        refresh_done;
   logic                        send_start;
   logic                        inhibit;
   logic                        req_rise;
   logic                        req_fall;
   logic                        is_ctrl;
   logic                        err_free;
   logic                        act;
   logic                        tx_en;
   logic                        rx_en;
   logic                        ext_mode;

   // Byte i of a 48-bit address as it goes on the wire, top byte first
   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
      addr_byte = a[8*(5-i) +: 8];
   endfunction

   // Merge a Wishbone write into a word under its byte selects
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   // Byte of the generated pause frame; FCS is appended downstream
   function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [47:0] sa,
                                             input logic [15:0] q);
      if (i < 6'd6) begin
         frame_byte = addr_byte(mac_fc_pkg::RESERVED_DA, i[2:0]);
      end else if (i < 6'd12) begin
         frame_byte = addr_byte(sa, 3'(i - 6'd6));
      end else begin
         case (i)
            6'd12:   frame_byte = mac_fc_pkg::CTRL_TYPE[15:8];
            6'd13:   frame_byte = mac_fc_pkg::CTRL_TYPE[7:0];
            6'd14:   frame_byte = mac_fc_pkg::PAUSE_OPCODE[15:8];
            6'd15:   frame_byte = mac_fc_pkg::PAUSE_OPCODE[7:0];
            6'd16:   frame_byte = q[15:8];
            6'd17:   frame_byte = q[7:0];
            default: frame_byte = 8'h00;
         endcase
      end
   endfunction

   assign tx_en    = ctrl_q[mac_fc_pkg::CTRL_TX_EN];
   assign rx_en    = ctrl_q[mac_fc_pkg::CTRL_RX_EN];
   assign ext_mode = ctrl_q[mac_fc_pkg::CTRL_EXT];

   //////////////////////////////////////////////////////////////////////////////
   // Wishbone classic slave, one wait state, unmapped reads give zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            case (wb_adr_i)
               mac_fc_pkg::OFS_CTRL:    wb_dat_o <= {27'h0, ctrl_q};
               mac_fc_pkg::OFS_ADDR_LO: wb_dat_o <= station_q[31:0];
               mac_fc_pkg::OFS_ADDR_HI: wb_dat_o <= {16'h0, station_q[47:32]};
               mac_fc_pkg::OFS_REFRESH: wb_dat_o <= {16'h0, refresh_q};
               mac_fc_pkg::OFS_STATUS:  wb_dat_o <= {14'h0, pend_q, inhibit, inh_count};
               default:                 wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Writes land on the edge where ack is high, as the master samples it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q    <= mac_fc_pkg::CTRL_RST;
         station_q <= mac_fc_pkg::STATION_RST;
         refresh_q <= mac_fc_pkg::REFRESH_RST;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
         case (wb_adr_i)
            mac_fc_pkg::OFS_CTRL:    ctrl_q <= 5'(merge({27'h0, ctrl_q}, wb_dat_i, wb_sel_i));
            mac_fc_pkg::OFS_ADDR_LO: station_q[31:0] <= merge(station_q[31:0], wb_dat_i, wb_sel_i);
            mac_fc_pkg::OFS_ADDR_HI: station_q[47:32] <=
               16'(merge({16'h0, station_q[47:32]}, wb_dat_i, wb_sel_i));
            mac_fc_pkg::OFS_REFRESH: refresh_q <= 16'(merge({16'h0, refresh_q}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Quantum divider: one tick every 3 clocks (60 ns), 512 bit times rounded up
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_q  <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == 2'(mac_fc_pkg::QUANTUM_CYC - 1));
         div_q  <= (div_q == 2'(mac_fc_pkg::QUANTUM_CYC - 1)) ? 2'h0 : div_q + 2'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Pause request capture; a single slot, so later requests overwrite
   assign send_start = (state_q == mac_fc_pkg::TX_IDLE) && pend_q;
   assign req_rise   = pause_req_valid && !req_prev_q;
   assign req_fall   = !pause_req_valid && req_prev_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         req_prev_q <= 1'b0;
         held_q     <= 1'b0;
      end else begin
         req_prev_q <= pause_req_valid;
         held_q     <= pause_req_valid && req_prev_q;
      end
   end

   // A new request in the start cycle still wins, so it stays pending for the next frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_q        <= 1'b0;
         pend_quanta_q <= 16'h0000;
         held_quanta_q <= 16'h0000;
      end else begin
         if (send_start) begin
            pend_q <= 1'b0;
         end
         if (tx_en && !ext_mode && pause_req_valid) begin
            pend_q        <= 1'b1;
            pend_quanta_q <= pause_req_quanta;
         end else if (tx_en && ext_mode) begin
            if (req_rise) begin
               pend_q        <= 1'b1;
               pend_quanta_q <= pause_req_quanta;
               held_quanta_q <= pause_req_quanta;
            end else if (pause_req_valid && req_prev_q && refresh_done) begin
               pend_q        <= 1'b1;
               pend_quanta_q <= held_quanta_q;
            end else if (req_fall && held_q && ctrl_q[mac_fc_pkg::CTRL_AUTO_ON]) begin
               pend_q        <= 1'b1;
               pend_quanta_q <= 16'h0000;
            end
         end
      end
   end

   // Refresh timer restarts on every pause frame and runs only while held
   quanta_counter refresh_ctr (
      .clock    (clock),
      .rst      (rst),
      .load     (send_start),
      .load_val (refresh_q),
      .tick     (tick_q && pause_req_valid && req_prev_q),
      .count_q  (),
      .done_q   (refresh_done)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Transmit arbiter: frames in flight always finish before a pause frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q        <= mac_fc_pkg::TX_IDLE;
         idx_q          <= 6'h00;
         frame_quanta_q <= 16'h0000;
         tx_ack         <= 1'b0;
         line_tx_valid  <= 1'b0;
         line_tx_data   <= 8'h00;
         line_tx_last   <= 1'b0;
      end else begin
         tx_ack        <= 1'b0;
         line_tx_valid <= 1'b0;
         line_tx_last  <= 1'b0;
         case (state_q)
            mac_fc_pkg::TX_IDLE: begin
               if (pend_q) begin
                  state_q        <= mac_fc_pkg::TX_PAUSE;
                  idx_q          <= 6'h00;
                  frame_quanta_q <= pend_quanta_q;
               end else if (tx_valid && !inhibit) begin
                  // First byte leaves next cycle: the client still holds it until it sees the ack
                  tx_ack  <= 1'b1;
                  state_q <= mac_fc_pkg::TX_CLIENT;
               end
            end
            mac_fc_pkg::TX_CLIENT: begin
               line_tx_valid <= 1'b1;
               line_tx_data  <= tx_data;
               line_tx_last  <= tx_last;
               if (tx_last) begin
                  state_q <= mac_fc_pkg::TX_IDLE;
               end
            end
            mac_fc_pkg::TX_PAUSE: begin
               line_tx_valid <= 1'b1;
               line_tx_data  <= frame_byte(idx_q, station_q, frame_quanta_q);
               line_tx_last  <= (idx_q == 6'(mac_fc_pkg::PAUSE_LEN - 1));
               idx_q         <= idx_q + 6'h01;
               if (idx_q == 6'(mac_fc_pkg::PAUSE_LEN - 1)) begin
                  state_q <= mac_fc_pkg::TX_IDLE;
               end
            end
            default: state_q <= mac_fc_pkg::TX_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Receive parser: fields are caught by byte position as the frame streams by
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rcnt_q   <= 7'h00;
         da_res_q <= 1'b0;
         da_sta_q <= 1'b0;
         type_q   <= 16'h0000;
         op_q     <= 16'h0000;
         rq_q     <= 16'h0000;
      end else if (line_rx_valid) begin
         rcnt_q <= line_rx_last ? 7'h00 : (rcnt_q == 7'h7F ? rcnt_q : rcnt_q + 7'h01);
         if (rcnt_q < 7'd6) begin
            da_res_q <= (rcnt_q == 7'd0 || da_res_q) &&
                        line_rx_data == addr_byte(mac_fc_pkg::RESERVED_DA, rcnt_q[2:0]);
            da_sta_q <= (rcnt_q == 7'd0 || da_sta_q) &&
                        line_rx_data == addr_byte(station_q, rcnt_q[2:0]);
         end
         if (rcnt_q == 7'd12 || rcnt_q == 7'd13) begin
            type_q <= {type_q[7:0], line_rx_data};
         end
         if (rcnt_q == 7'd14 || rcnt_q == 7'd15) begin
            op_q <= {op_q[7:0], line_rx_data};
         end
         if (rcnt_q == 7'd16 || rcnt_q == 7'd17) begin
            rq_q <= {rq_q[7:0], line_rx_data};
         end
      end
   end

   // Verdict on the last byte; rcnt_q counts the bytes before it
   assign is_ctrl  = (rcnt_q >= 7'd17) && (type_q == mac_fc_pkg::CTRL_TYPE);
   assign err_free = line_rx_crc_ok &&
                     (rcnt_q == 7'(mac_fc_pkg::CTRL_LEN - 1) || ctrl_q[mac_fc_pkg::CTRL_LEN_DIS]);
   assign act      = line_rx_valid && line_rx_last && rx_en && is_ctrl && err_free &&
                     (da_res_q || da_sta_q) && op_q == mac_fc_pkg::PAUSE_OPCODE;

   // Client delivery one cycle behind the line, good flag only on the last byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_valid      <= 1'b0;
         rx_data       <= 8'h00;
         rx_last       <= 1'b0;
         rx_good       <= 1'b0;
         rx_stat_valid <= 1'b0;
         rx_stat_word  <= 32'h00000000;
      end else begin
         rx_valid      <= line_rx_valid;
         rx_data       <= line_rx_data;
         rx_last       <= line_rx_valid && line_rx_last;
         rx_good       <= 1'b0;
         rx_stat_valid <= line_rx_valid && line_rx_last;
         if (line_rx_valid && line_rx_last) begin
            if (is_ctrl) begin
               rx_good <= err_free && !act;
            end else begin
               rx_good <= line_rx_crc_ok;
            end
            rx_stat_word <= 32'h00000000;
            rx_stat_word[mac_fc_pkg::STAT_GOOD] <= is_ctrl ? err_free : line_rx_crc_ok;
            rx_stat_word[mac_fc_pkg::STAT_CTRL] <= is_ctrl;
         end
      end
   end

   // Inhibit timer; a zero-quanta pause loads zero and ends it at once
   quanta_counter inhibit_ctr (
      .clock    (clock),
      .rst      (rst),
      .load     (act),
      .load_val (rq_q),
      .tick     (tick_q),
      .count_q  (inh_count),
      .done_q   ()
   );
   assign inhibit = (inh_count != 16'h0000);

   //////////////////////////////////////////////////////////////////////////////
   // Checks on the design's own state and outputs
   AST_REQ_CAPTURE: assert property (@(posedge clock) disable iff (rst)
      (tx_en && !ext_mode && pause_req_valid && !send_start) |=>
      (pend_q && pend_quanta_q == $past(pause_req_quanta)))
      else $error("pause request quanta not captured");
   AST_NO_ABORT: assert property (@(posedge clock) disable iff (rst)
      (state_q == mac_fc_pkg::TX_CLIENT && !tx_last) |=> state_q == mac_fc_pkg::TX_CLIENT)
      else $error("client frame cut short");
   AST_PAUSE_FIRST: assert property (@(posedge clock) disable iff (rst)
      send_start |=> (state_q == mac_fc_pkg::TX_PAUSE && !tx_ack))
      else $error("pause frame did not start ahead of client");
   AST_PAUSE_INHIBITED: assert property (@(posedge clock) disable iff (rst)
      (send_start && inhibit) |=> ##1 (line_tx_valid && line_tx_data == 8'h01))
      else $error("pause frame blocked by inhibit");
   AST_FRAME_PARAM: assert property (@(posedge clock) disable iff (rst)
      (state_q == mac_fc_pkg::TX_PAUSE && idx_q == 6'd16) |=>
      (line_tx_data == frame_quanta_q[15:8]) ##1 (line_tx_data == frame_quanta_q[7:0]))
      else $error("pause parameter field wrong");
   AST_ACK_WITHHELD: assert property (@(posedge clock) disable iff (rst)
      inhibit |=> !tx_ack)
      else $error("transmit acknowledge given while inhibited");
   AST_RESUME_ZERO: assert property (@(posedge clock) disable iff (rst)
      (tx_en && ext_mode && req_fall && held_q && ctrl_q[mac_fc_pkg::CTRL_AUTO_ON]) |=>
      (pend_q && pend_quanta_q == 16'h0000))
      else $error("resume frame not queued");
   AST_ZERO_CANCEL: assert property (@(posedge clock) disable iff (rst)
      (act && rq_q == 16'h0000) |=> !inhibit)
      else $error("zero quanta did not end inhibit");
   AST_ACTED_MARK: assert property (@(posedge clock) disable iff (rst)
      act |=> (rx_last && !rx_good && rx_stat_word[0] && rx_stat_word[20]))
      else $error("acted pause frame marked wrongly");
   AST_CTRL_STAT: assert property (@(posedge clock) disable iff (rst)
      (line_rx_valid && line_rx_last && is_ctrl) |=> (rx_stat_valid && rx_stat_word[20]))
      else $error("control frame statistics bit missing");
endmodule

// file: mac_link_partner.sv
// Link partner model: sends 64-byte MAC control frames with a settable opcode into the receive side
`timescale 1ns/1ps
module mac_link_partner (
   input  wire logic        clock,
   input  wire logic        go,
   input  wire logic [15:0] quanta,
   input  wire logic        crc_good,
   input  wire logic [15:0] opcode,
   output logic             rx_valid = 1'b0,
   output logic      [7:0]  rx_data = 8'h00,
   output logic             rx_last = 1'b0,
   output logic             rx_crc_ok = 1'b0
);
   logic [511:0] fr;
   int           n = 0;
   // Reserved DA, arbitrary SA, control type, opcode, quanta, pad, FCS
   assign fr = {mac_fc_pkg::RESERVED_DA, 48'h0A0B0C0D0E0F, mac_fc_pkg::CTRL_TYPE, opcode,
                quanta, 336'h0, 32'hC3C3C3C3};
   // Byte per cycle, no gaps; idle data toggles so no stale byte looks valid
   always @(posedge clock) begin
      if (go || (n > 0 && n < 64)) begin
         rx_valid <= 1'b1;
         rx_data <= fr[511-8*n -: 8];
         rx_last <= (n == 63);
         rx_crc_ok <= crc_good && n == 63;
         n <= n + 1;
      end else begin
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
         rx_last <= 1'b0;
         rx_crc_ok <= 1'b0;
         n <= 0;
      end
   end
endmodule

// file: mac_pause_flow_control_tb.sv
// Self-checking bench for the pause flow control block
`timescale 1ns/1ps
module mac_pause_flow_control_tb;
   logic        clock = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, tx_valid = 1'b0;
   logic        pause_req_valid = 1'b0, tx_last = 1'b0, go = 1'b0, crc_good = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00, tx_data = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [15:0] pause_req_quanta = 16'h0000, quanta = 16'h0000, op = mac_fc_pkg::PAUSE_OPCODE;
   logic [7:0]  got_tail;
   int          rx_beats = 0, got_beats;
   logic [31:0] wb_dat_i = 32'h0;
   logic        wb_ack_o, tx_ack, line_tx_valid, line_tx_last, line_rx_valid, line_rx_last, line_rx_crc_ok;
   logic        rx_valid, rx_last, rx_good, rx_stat_valid, got_good;
   logic [7:0]  line_tx_data, line_rx_data, rx_data, tx_buf[64];
   logic [31:0] wb_dat_o, rx_stat_word, got_stat, rd;
   int          fail_count = 0, n_tests = 0, frames = 0, tx_idx = 0, tx_len = 0, acks = 0, f0;
   localparam logic [7:0]  radr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
   localparam logic [31:0] rexp[6] = '{32'h0, mac_fc_pkg::STATION_RST[31:0], 32'h0200, 32'hFF00, 32'h0, 32'h0};
   localparam logic [143:0] hdr = {mac_fc_pkg::RESERVED_DA, mac_fc_pkg::STATION_RST, mac_fc_pkg::CTRL_TYPE,
                                   mac_fc_pkg::PAUSE_OPCODE, 16'hABCD};
   mac_pause_flow_control uut (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .pause_req_valid, .pause_req_quanta, .tx_valid, .tx_data, .tx_last, .tx_ack,
      .line_tx_valid, .line_tx_data, .line_tx_last, .line_rx_valid, .line_rx_data, .line_rx_last,
      .line_rx_crc_ok, .rx_valid, .rx_data, .rx_last, .rx_good, .rx_stat_valid, .rx_stat_word);
   mac_link_partner peer (.clock, .go, .quanta, .crc_good, .rx_valid(line_rx_valid), .rx_data(line_rx_data),
      .rx_last(line_rx_last), .rx_crc_ok(line_rx_crc_ok), .opcode(op));
   initial begin
      forever #10 clock = ~clock;
   end
   // Collects transmitted frames, receive verdicts and client acks
   always @(posedge clock) begin
      if (line_tx_valid === 1'b1) begin
         if (tx_idx < 64) tx_buf[tx_idx] = line_tx_data;
         tx_idx++;
         if (line_tx_last === 1'b1) begin
            frames++;
            tx_len = tx_idx;
            tx_idx = 0;
         end
      end
      if (rx_valid === 1'b1) rx_beats++;
      if (rx_last === 1'b1) begin
         got_good  = rx_good; // Verdict kept, frame dropped as client
         got_beats = rx_beats;
         got_tail  = rx_data;
         rx_beats  = 0;
      end
      if (rx_stat_valid === 1'b1) got_stat = rx_stat_word;
      if (tx_ack === 1'b1) acks++;
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Wishbone classic cycle; read data left in rd
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, 4'hF};
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (k >= 50) fail_count++;
      if (k >= 50) complete_run();
   endtask
   // Counters are read at the falling edge, clear of the monitor's updates
   task automatic await(ref int cnt, input int n);
      for (int k = 0; k < 400 && cnt < n; k++) @(negedge clock);
      if (cnt < n) fail_count++;
      if (cnt < n) complete_run();
   endtask
   task automatic req(input logic [15:0] q, input int n);
      @(posedge clock);
      {pause_req_quanta, pause_req_valid} <= {q, 1'b1};
      repeat (n) @(posedge clock);
      pause_req_valid <= 1'b0;
   endtask
   task automatic send(input logic [15:0] q, input logic ok, input int n);
      @(posedge clock);
      {quanta, crc_good, go} <= {q, ok, 1'b1};
      @(posedge clock);
      go <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   // Client frame of n header bytes: first byte held until tx_ack is seen, then one byte a cycle
   task automatic client(input int n);
      int k;
      @(posedge clock);
      {tx_valid, tx_last, tx_data} <= {1'b1, n == 1, hdr[143 -: 8]};
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (tx_ack !== 1'b1 && k < 400);
      for (int i = 1; i < n; i++) begin
         {tx_last, tx_data} <= {i == n - 1, hdr[143-8*i -: 8]};
         @(posedge clock);
      end
      tx_valid <= 1'b0;
      if (k >= 400) fail_count++;
      if (k >= 400) complete_run();
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      // Reset values; status ignores writes, unmapped reads zero
      wb(1'b1, mac_fc_pkg::OFS_STATUS, 32'hFFFFFFFF);
      foreach (radr[i]) begin
         wb(1'b0, radr[i], 32'h0);
         check("register", rexp[i], rd);
      end
      // Idle start, then two requests while busy give one frame with the latest quanta
      wb(1'b1, mac_fc_pkg::OFS_CTRL, 32'h01);
      req(16'h1111, 1);
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("start", 1, line_tx_valid);
      req(16'h1234, 1);
      req(16'hABCD, 1);
      await(frames, 2);
      repeat (100) @(posedge clock);
      check("frames", 2, frames);
      check("length", 60, tx_len);
      for (int i = 0; i < 18; i++) check("byte", hdr[143-8*i -: 8], tx_buf[i]);
      // Acted pause holds the client off; our request still goes out; zero quanta frees it
      wb(1'b1, mac_fc_pkg::OFS_CTRL, 32'h03);
      send(16'h0100, 1'b1, 70);
      check("acted good", 0, got_good);
      check("stat", 32'h100001, got_stat & 32'h100001);
      check("rx beats", 64, got_beats);
      check("rx tail", 32'hC3, got_tail);
      wb(1'b0, mac_fc_pkg::OFS_STATUS, 32'h0);
      check("inhibit", 1, rd[16]);
      {tx_valid, tx_last, tx_data} <= {2'b11, 8'h5A};
      req(16'h0000, 1);
      await(frames, 3);
      check("held", 0, acks);
      send(16'h0000, 1'b1, 60);
      for (int k = 0; k < 20 && tx_ack !== 1'b1; k++) @(posedge clock);
      tx_valid <= 1'b0;
      @(negedge clock);
      check("released", 1, acks);
      // A control frame with a foreign opcode is left to the client, marked good
      @(posedge clock);
      op <= 16'h0002;
      send(16'h0009, 1'b1, 70);
      check("foreign good", 1, got_good);
      wb(1'b0, mac_fc_pkg::OFS_STATUS, 32'h0);
      op <= mac_fc_pkg::PAUSE_OPCODE;
      check("foreign ignored", 0, rd[16]);
      // Flow control off: error-free frame good, no action; bad FCS marked bad
      wb(1'b1, mac_fc_pkg::OFS_CTRL, 32'h00);
      send(16'h0005, 1'b1, 70);
      check("passed good", 1, got_good);
      wb(1'b0, mac_fc_pkg::OFS_STATUS, 32'h0);
      check("no inhibit", 0, rd[16]);
      send(16'h0005, 1'b0, 70);
      check("bad", 0, {got_good, got_stat[0]});
      // Flow control off: a client-built pause frame passes byte for byte
      f0 = frames;
      client(18);
      await(frames, f0 + 1);
      check("client length", 18, tx_len);
      for (int i = 0; i < 18; i++) check("client byte", hdr[143-8*i -: 8], tx_buf[i]);
      // Extended mode: held request refreshes, release sends zero quanta
      wb(1'b1, mac_fc_pkg::OFS_REFRESH, 32'h1);
      wb(1'b1, mac_fc_pkg::OFS_CTRL, 32'h0D);
      f0 = frames;
      req(16'hFFFF, 200);
      repeat (250) @(posedge clock);
      check("refreshes", 1, frames - f0 >= 4);
      check("resume", 0, {tx_buf[16], tx_buf[17]});
      complete_run();
   end
endmodule
